//--- hdl/pgt_top.sv
// Power-good mask bank with serial register port and trees for outputs 1 and 4
//
// Behaviour
// - Output 1 second mask bit7 gates control 5
// - Output 1 second mask bit6 gates control 4
// - Output 1 second mask bit5 gates control 2
// - Output 1 second mask bit4 gates control 1
// - Output 1 second mask bit3 gates termination
// - Output 1 second mask bit2 gates shared source
// - Output 1 second mask bit1 gates switch B1
// - Output 1 second mask bit0 gates regulator 3
// - Output 4 first mask bit7 gates regulator 2
// - Output 4 first mask bit6 gates switch A1
// - Output 4 first mask bits5..0 gate step-downs
// - Output 4 second mask bits7,6 gate controls 5,4
// - Output 4 second mask bits5,4 gate controls 2,1
// - Output 4 second mask bit3 gates termination
// - Output 4 bit2 shared source chosen by programming
// - Output 4 second mask bit1 gates switch B1
// - Output 4 second mask bit0 gates regulator 3
// - Output 4 first mask at A6h, programmed default
// - Output 4 second mask at A7h, programmed default
// - Output 1 second mask at A5h, programmed default
`timescale 1ns/1ps
module pgt_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [5:0] step_down_pg,
  input wire logic regulator_1_pg,
  input wire logic regulator_2_pg,
  input wire logic regulator_3_pg,
  input wire logic switch_a_one_pg,
  input wire logic switch_b_one_pg,
  input wire logic switch_b_two_pg,
  input wire logic termination_pg,
  input wire logic control_input_1,
  input wire logic control_input_2,
  input wire logic control_input_4,
  input wire logic control_input_5,
  input wire logic [7:0] pg_output_1_mask_a,
  input wire logic [7:0] otp_pg_output_1_mask_b,
  input wire logic [7:0] otp_pg_output_4_mask_a,
  input wire logic [7:0] otp_pg_output_4_mask_b,
  input wire logic otp_shared_is_regulator,
  output logic pg_output_1,
  output logic pg_output_4
);
  pgt_pkg::pgt_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] ptr;
  logic rw;
  logic addr_hit;
  logic ptr_load;
  logic ptr_inc;
  logic wr_go;
  logic otp_loaded;
  logic shared_sel;
  logic shared_pg;
  logic [7:0] pg_output_1_mask_b;
  logic [7:0] pg_output_4_mask_a;
  logic [7:0] pg_output_4_mask_b;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic [7:0] rd_byte;

  pgt_tree_if t1_if();
  pgt_tree_if t4_if();
  pgt_line_if ln_if();

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Unmapped offsets read as a fixed byte and ignore writes
  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] m1b,
                                          input logic [7:0] m4a, input logic [7:0] m4b);
    logic [7:0] val;
    val = pgt_pkg::PGT_UNMAPPED_RD;
    if (ofs == pgt_pkg::PGT_OFS_PG1_MASK_B) begin
      val = m1b;
    end else if (ofs == pgt_pkg::PGT_OFS_PG4_MASK_A) begin
      val = m4a;
    end else if (ofs == pgt_pkg::PGT_OFS_PG4_MASK_B) begin
      val = m4b;
    end
    return val;
  endfunction

  assign rd_byte = reg_read(ptr, pg_output_1_mask_b, pg_output_4_mask_a, pg_output_4_mask_b);

  // ----------------------------------------
  // Line conditioning
  // ----------------------------------------
  pgt_line u_line (
    .clk(clk),
    .arst_n(arst_n),
    .scl(scl),
    .sda(sda_in),
    .lb(ln_if.line)
  );

  // ----------------------------------------
  // Serial protocol next state
  // ----------------------------------------
  // Data is sampled on clock rise and changed on clock fall
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    addr_hit = 1'b0;
    ptr_load = 1'b0;
    ptr_inc = 1'b0;
    wr_go = 1'b0;
    if (ln_if.start) begin
      next_state = pgt_pkg::PGT_ADDR;
      next_cnt = 4'h0;
    end else if (ln_if.stop) begin
      next_state = pgt_pkg::PGT_IDLE;
    end else begin
      unique case (state)
        pgt_pkg::PGT_IDLE: begin
          next_cnt = 4'h0;
        end
        pgt_pkg::PGT_ADDR: begin
          if (ln_if.scl_rise) begin
            next_shift = {shift[6:0], ln_if.sda};
            next_cnt = cnt + 4'h1;
          end else if (ln_if.scl_fall && cnt == pgt_pkg::PGT_BYTE_BITS) begin
            next_cnt = 4'h0;
            if (shift[7:1] == DEV_ADDR) begin
              addr_hit = 1'b1;
              next_state = pgt_pkg::PGT_AACK;
            end else begin
              next_state = pgt_pkg::PGT_IDLE;
            end
          end
        end
        pgt_pkg::PGT_AACK: begin
          if (ln_if.scl_fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_state = pgt_pkg::PGT_RDATA;
              next_shift = rd_byte;
              ptr_inc = 1'b1;
            end else begin
              next_state = pgt_pkg::PGT_REG;
            end
          end
        end
        pgt_pkg::PGT_REG: begin
          if (ln_if.scl_rise) begin
            next_shift = {shift[6:0], ln_if.sda};
            next_cnt = cnt + 4'h1;
          end else if (ln_if.scl_fall && cnt == pgt_pkg::PGT_BYTE_BITS) begin
            next_cnt = 4'h0;
            ptr_load = 1'b1;
            next_state = pgt_pkg::PGT_RACK;
          end
        end
        pgt_pkg::PGT_RACK: begin
          if (ln_if.scl_fall) begin
            next_cnt = 4'h0;
            next_state = pgt_pkg::PGT_WDATA;
          end
        end
        pgt_pkg::PGT_WDATA: begin
          if (ln_if.scl_rise) begin
            next_shift = {shift[6:0], ln_if.sda};
            next_cnt = cnt + 4'h1;
          end else if (ln_if.scl_fall && cnt == pgt_pkg::PGT_BYTE_BITS) begin
            next_cnt = 4'h0;
            wr_go = 1'b1;
            ptr_inc = 1'b1;
            next_state = pgt_pkg::PGT_WACK;
          end
        end
        pgt_pkg::PGT_WACK: begin
          if (ln_if.scl_fall) begin
            next_cnt = 4'h0;
            next_state = pgt_pkg::PGT_WDATA;
          end
        end
        pgt_pkg::PGT_RDATA: begin
          if (ln_if.scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (ln_if.scl_fall && cnt == pgt_pkg::PGT_BYTE_BITS) begin
            next_cnt = 4'h0;
            next_state = pgt_pkg::PGT_MACK;
          end else if (ln_if.scl_fall) begin
            next_shift = {shift[6:0], 1'b0};
          end
        end
        pgt_pkg::PGT_MACK: begin
          // A high acknowledge from the master ends the read
          if (ln_if.scl_rise && ln_if.sda) begin
            next_state = pgt_pkg::PGT_IDLE;
          end else if (ln_if.scl_fall) begin
            next_cnt = 4'h0;
            next_state = pgt_pkg::PGT_RDATA;
            next_shift = rd_byte;
            ptr_inc = 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial protocol state
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pgt_pkg::PGT_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
    end
  end

  // Direction bit of the address byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rw <= 1'b0;
    end else if (addr_hit) begin
      rw <= shift[0];
    end
  end

  // Register pointer auto-increments after each written byte and as each read byte is loaded
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr <= 8'h00;
    end else if (ptr_load) begin
      ptr <= shift;
    end else if (ptr_inc) begin
      ptr <= ptr + 8'h01;
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // Open drain: the pin is only ever pulled low, never driven high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= (next_state == pgt_pkg::PGT_AACK) || (next_state == pgt_pkg::PGT_RACK) ||
                (next_state == pgt_pkg::PGT_WACK) ||
                ((next_state == pgt_pkg::PGT_RDATA) && !next_shift[7]);
    end
  end

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  // Async reset can only load a constant; programmed defaults follow on the first edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      otp_loaded <= 1'b0;
      shared_sel <= 1'b0;
      pg_output_1_mask_b <= pgt_pkg::PGT_MASK_RST;
      pg_output_4_mask_a <= pgt_pkg::PGT_MASK_RST;
      pg_output_4_mask_b <= pgt_pkg::PGT_MASK_RST;
    end else if (!otp_loaded) begin
      otp_loaded <= 1'b1;
      shared_sel <= otp_shared_is_regulator;
      pg_output_1_mask_b <= otp_pg_output_1_mask_b;
      pg_output_4_mask_a <= otp_pg_output_4_mask_a;
      pg_output_4_mask_b <= otp_pg_output_4_mask_b;
    end else if (wr_go) begin
      if (ptr == pgt_pkg::PGT_OFS_PG1_MASK_B) begin
        pg_output_1_mask_b <= shift;
      end
      if (ptr == pgt_pkg::PGT_OFS_PG4_MASK_A) begin
        pg_output_4_mask_a <= shift;
      end
      if (ptr == pgt_pkg::PGT_OFS_PG4_MASK_B) begin
        pg_output_4_mask_b <= shift;
      end
    end
  end

  // ----------------------------------------
  // Tree sources
  // ----------------------------------------
  assign shared_pg = shared_sel ? regulator_1_pg : switch_b_two_pg;

  // Same source order in both second masks, so one vector serves both trees
  always_comb begin
    src_a = 8'h00;
    src_b = 8'h00;
    src_a[pgt_pkg::PGT_A_REG2] = regulator_2_pg;
    src_a[pgt_pkg::PGT_A_SW_A_ONE] = switch_a_one_pg;
    src_a[pgt_pkg::PGT_A_STEP_HI:pgt_pkg::PGT_A_STEP_LO] = step_down_pg;
    src_b[pgt_pkg::PGT_B_CI5] = control_input_5;
    src_b[pgt_pkg::PGT_B_CI4] = control_input_4;
    src_b[pgt_pkg::PGT_B_CI2] = control_input_2;
    src_b[pgt_pkg::PGT_B_CI1] = control_input_1;
    src_b[pgt_pkg::PGT_B_TERM] = termination_pg;
    src_b[pgt_pkg::PGT_B_SHARED] = shared_pg;
    src_b[pgt_pkg::PGT_B_SW_B_ONE] = switch_b_one_pg;
    src_b[pgt_pkg::PGT_B_REG3] = regulator_3_pg;
  end

  // Output 1 takes its first mask from outside this bank
  assign t1_if.mask_a = pg_output_1_mask_a;
  assign t1_if.mask_b = pg_output_1_mask_b;
  assign t1_if.src_a = src_a;
  assign t1_if.src_b = src_b;
  assign t4_if.mask_a = pg_output_4_mask_a;
  assign t4_if.mask_b = pg_output_4_mask_b;
  assign t4_if.src_a = src_a;
  assign t4_if.src_b = src_b;

  pgt_tree u_tree_1 (
    .clk(clk),
    .arst_n(arst_n),
    .tr(t1_if.tree)
  );

  pgt_tree u_tree_4 (
    .clk(clk),
    .arst_n(arst_n),
    .tr(t4_if.tree)
  );

  assign pg_output_1 = t1_if.good;
  assign pg_output_4 = t4_if.good;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ci5_out1;
    @(posedge clk) disable iff (!arst_n)
    (!control_input_5 && !pg_output_1_mask_b[pgt_pkg::PGT_B_CI5]) |=> !pg_output_1;
  endproperty
  a_ci5_out1: assert property (p_ci5_out1) else $error("control 5 not gating output 1");

  property p_switch_b_one_out1;
    @(posedge clk) disable iff (!arst_n)
    (!switch_b_one_pg && !pg_output_1_mask_b[pgt_pkg::PGT_B_SW_B_ONE]) |=> !pg_output_1;
  endproperty
  a_switch_b_one_out1: assert property (p_switch_b_one_out1) else $error("switch B1 not gating output 1");

  property p_reg3_out1;
    @(posedge clk) disable iff (!arst_n)
    (!regulator_3_pg && !pg_output_1_mask_b[pgt_pkg::PGT_B_REG3]) |=> !pg_output_1;
  endproperty
  a_reg3_out1: assert property (p_reg3_out1) else $error("regulator 3 not gating output 1");

  property p_reg2_out4;
    @(posedge clk) disable iff (!arst_n)
    (!regulator_2_pg && !pg_output_4_mask_a[pgt_pkg::PGT_A_REG2]) |=> !pg_output_4;
  endproperty
  a_reg2_out4: assert property (p_reg2_out4) else $error("regulator 2 not gating output 4");

  property p_step_out4;
    @(posedge clk) disable iff (!arst_n)
    (|(~step_down_pg & ~pg_output_4_mask_a[pgt_pkg::PGT_A_STEP_HI:pgt_pkg::PGT_A_STEP_LO])) |=> !pg_output_4;
  endproperty
  a_step_out4: assert property (p_step_out4) else $error("step-down not gating output 4");

  property p_shared_out4;
    @(posedge clk) disable iff (!arst_n)
    (shared_sel && !regulator_1_pg && !pg_output_4_mask_b[pgt_pkg::PGT_B_SHARED]) ##1 1'b1 |-> !pg_output_4;
  endproperty
  a_shared_out4: assert property (p_shared_out4) else $error("shared source not gating output 4");

  property p_all_masked;
    @(posedge clk) disable iff (!arst_n)
    (&pg_output_4_mask_a && &pg_output_4_mask_b) [*2] |-> pg_output_4;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("fully masked output 4 not good");

  property p_wr_a6;
    @(posedge clk) disable iff (!arst_n)
    (otp_loaded && wr_go && ptr == pgt_pkg::PGT_OFS_PG4_MASK_A) |=> (pg_output_4_mask_a == $past(shift));
  endproperty
  a_wr_a6: assert property (p_wr_a6) else $error("write to A6h lost");

  property p_wr_a7;
    @(posedge clk) disable iff (!arst_n)
    (otp_loaded && wr_go && ptr == pgt_pkg::PGT_OFS_PG4_MASK_B) |=> (pg_output_4_mask_b == $past(shift));
  endproperty
  a_wr_a7: assert property (p_wr_a7) else $error("write to A7h lost");

  // Sampled reset term keeps the release edge itself, still in reset, from starting an attempt
  property p_otp_a5;
    @(posedge clk) disable iff (!arst_n)
    (arst_n && !otp_loaded) |=> (pg_output_1_mask_b == $past(otp_pg_output_1_mask_b)) && otp_loaded;
  endproperty
  a_otp_a5: assert property (p_otp_a5) else $error("A5h default not loaded");
endmodule

//--- hdl/pgt_pkg.sv
// Package: register map, field positions and protocol states of the power-good mask bank
package pgt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PGT_OFS_PG1_MASK_B = 8'ha5;
  localparam logic [7:0] PGT_OFS_PG4_MASK_A = 8'ha6;
  localparam logic [7:0] PGT_OFS_PG4_MASK_B = 8'ha7;

  // ----------------------------------------
  // Reset and read-back values
  // ----------------------------------------
  // Held only until the programmed defaults are copied in
  localparam logic [7:0] PGT_MASK_RST = 8'h00;
  localparam logic [7:0] PGT_UNMAPPED_RD = 8'h00;

  // ----------------------------------------
  // Second mask field positions
  // ----------------------------------------
  localparam int PGT_B_CI5 = 7;
  localparam int PGT_B_CI4 = 6;
  localparam int PGT_B_CI2 = 5;
  localparam int PGT_B_CI1 = 4;
  localparam int PGT_B_TERM = 3;
  localparam int PGT_B_SHARED = 2;
  localparam int PGT_B_SW_B_ONE = 1;
  localparam int PGT_B_REG3 = 0;

  // ----------------------------------------
  // First mask field positions
  // ----------------------------------------
  localparam int PGT_A_REG2 = 7;
  localparam int PGT_A_SW_A_ONE = 6;
  localparam int PGT_A_STEP_HI = 5;
  localparam int PGT_A_STEP_LO = 0;

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  localparam logic [3:0] PGT_BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    PGT_IDLE, PGT_ADDR, PGT_AACK, PGT_REG, PGT_RACK,
    PGT_WDATA, PGT_WACK, PGT_RDATA, PGT_MACK
  } pgt_state_t;
endpackage

//--- hdl/pgt_if.sv
// Interfaces: power-good tree inputs and conditioned serial line events
`timescale 1ns/1ps
interface pgt_tree_if;
  logic [7:0] mask_a, mask_b, src_a, src_b;
  logic good;
  modport tree (input mask_a, input mask_b, input src_a, input src_b, output good);
  modport ctrl (output mask_a, output mask_b, output src_a, output src_b, input good);
endinterface

interface pgt_line_if;
  logic scl_rise, scl_fall, start, stop, sda;
  modport line (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport proto (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

//--- hdl/pgt_tree.sv
// Power-good tree: one output formed from two masks and sixteen sources
`timescale 1ns/1ps
module pgt_tree (
  input wire logic clk,
  input wire logic arst_n,
  pgt_tree_if.tree tr
);
  // ----------------------------------------
  // Combine
  // ----------------------------------------
  // A set mask bit forces its source good, so it can never hold the output low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tr.good <= 1'b0;
    end else begin
      tr.good <= (&(tr.src_a | tr.mask_a)) & (&(tr.src_b | tr.mask_b));
    end
  end
endmodule

//--- hdl/pgt_line.sv
// Serial line conditioner: clock edges, start and stop conditions
`timescale 1ns/1ps
module pgt_line (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  pgt_line_if.line lb
);
  logic scl_q;
  logic sda_q;

  // ----------------------------------------
  // Edge and condition detect
  // ----------------------------------------
  // Line idles high, so the previous samples reset to one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      lb.scl_rise <= 1'b0;
      lb.scl_fall <= 1'b0;
      lb.start <= 1'b0;
      lb.stop <= 1'b0;
      lb.sda <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      lb.scl_rise <= !scl_q && scl;
      lb.scl_fall <= scl_q && !scl;
      lb.start <= scl_q && scl && sda_q && !sda; // Data falls while clock high
      lb.stop <= scl_q && scl && !sda_q && sda;
      lb.sda <= sda;
    end
  end
endmodule

//--- tb/pgt_master_model.sv
// Serial register port master: drives clock and data lines and reads the wire back
`timescale 1ns/1ps
module pgt_master_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // Released lines idle high through the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Three clocks a quarter keeps each clock level above the four-clock minimum
  task automatic wait_q(input int n);
    repeat (3 * n) @(posedge clk);
  endtask

  // Start, also a repeated start after an acknowledge
  task automatic start();
    sda_drv <= 1'b1;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_drv <= 1'b0;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask

  task automatic stop();
    sda_drv <= 1'b0;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_drv <= 1'b1;
    wait_q(2);
  endtask

  // Data moves only while the clock is low, so no false start or stop is made
  task automatic one_bit(input logic b, output logic seen);
    sda_drv <= b;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    seen = sda_wire;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(b[i], s);
    end
    one_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, s);
      b[i] = s;
    end
    one_bit(nack, s);
  endtask

  // Byte run from an offset; ok stays high only if every byte was acknowledged
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d [$],
                            output logic ok);
    logic a;
    start();
    send_byte({dev, 1'b0}, ok);
    send_byte(ofs, a);
    ok &= a;
    foreach (d[i]) begin
      send_byte(d[i], a);
      ok &= a;
    end
    stop();
  endtask

  // Pointer set, repeated start, n bytes read; the last byte is refused
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ofs, input int n,
                           output logic [7:0] q [$]);
    logic a;
    logic [7:0] b;
    q = {};
    start();
    send_byte({dev, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      recv_byte(i == n - 1, b);
      q.push_back(b);
    end
    stop();
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the power-good mask bank and its serial port
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] DEV = 7'h2a;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic pg1;
  logic pg4;
  logic sel = 1'b0;
  logic [7:0] ma1 = 8'h00;
  logic [7:0] o1b = 8'h00;
  logic [7:0] o4a = 8'h00;
  logic [7:0] o4b = 8'h00;
  logic [7:0] r1b;
  logic [7:0] r4a;
  logic [7:0] r4b;
  // Sources: 5..0 step-downs, 6 switch A1, 7 reg 2, 8 reg 3, 9 switch B1, 10 reg 1,
  // 11 switch B2, 12 termination, 13..16 control inputs 1, 2, 4, 5
  logic [16:0] src = 17'h1ffff;
  logic [31:0] seed = 32'h00008363;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 clk = ~clk;
  // Open-drain wire: the device pull-down wins over the master's release
  assign sda_in = sda_drv & ~sda_oe;

  pgt_top #(.DEV_ADDR(DEV)) pgt_top_inst (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .step_down_pg(src[5:0]), .switch_a_one_pg(src[6]), .regulator_2_pg(src[7]),
    .regulator_3_pg(src[8]), .switch_b_one_pg(src[9]), .regulator_1_pg(src[10]),
    .switch_b_two_pg(src[11]), .termination_pg(src[12]), .control_input_1(src[13]),
    .control_input_2(src[14]), .control_input_4(src[15]), .control_input_5(src[16]),
    .pg_output_1_mask_a(ma1), .otp_pg_output_1_mask_b(o1b), .otp_pg_output_4_mask_a(o4a),
    .otp_pg_output_4_mask_b(o4b), .otp_shared_is_regulator(sel), .pg_output_1(pg1), .pg_output_4(pg4)
  );

  pgt_master_model pgt_master_model_inst (.clk(clk), .sda_wire(sda_in), .scl(scl), .sda_drv(sda_drv));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Masked sources count as good, so only unmasked failures pull an output low
  function automatic logic good(input logic [7:0] ma, input logic [7:0] mb, input logic [16:0] s);
    logic [7:0] sb;
    sb = {s[16:13], s[12], sel ? s[10] : s[11], s[9], s[8]};
    return (&(s[7:0] | ma)) & (&(sb | mb));
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      give_verdict();
    end
  end

  // Sources and output 1 first mask change, then both outputs after the tree latency
  task automatic apply(input logic [16:0] s, input logic [7:0] m);
    @(posedge clk);
    src <= s;
    ma1 <= m;
    repeat (3) @(posedge clk);
    chk("pg_output_1", {7'h00, pg1}, {7'h00, good(m, r1b, s)});
    chk("pg_output_4", {7'h00, pg4}, {7'h00, good(r4a, r4b, s)});
  endtask

  // Reads the three masks plus the unmapped place after them, walking the pointer
  task automatic check_regs();
    logic [7:0] q [$];
    pgt_master_model_inst.read_regs(DEV, pgt_pkg::PGT_OFS_PG1_MASK_B, 4, q);
    chk("mask_1b", q[0], r1b);
    chk("mask_4a", q[1], r4a);
    chk("mask_4b", q[2], r4b);
    chk("unmapped", q[3], pgt_pkg::PGT_UNMAPPED_RD);
    chk("sda_out", {7'h00, sda_out}, 8'h00);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [23:0] d, input logic exp_ok);
    logic ok;
    pgt_master_model_inst.write_regs(dev, ofs, '{d[23:16], d[15:8], d[7:0]}, ok);
    chk("ack", {7'h00, ok}, {7'h00, exp_ok});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] m;
    for (int ph = 0; ph < 2; ph++) begin
      // Second pass runs again with the other shared-source choice
      r = rnd();
      @(posedge clk);
      arst_n <= 1'b0;
      sel <= ph[0];
      o1b <= r[7:0];
      o4a <= r[15:8];
      o4b <= r[23:16];
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      r1b = r[7:0];
      r4a = r[15:8];
      r4b = r[23:16];
      repeat (4) @(posedge clk);
      check_regs();
      // One-hot masks, then none and all; output 1 second mask is the OR of both halves
      for (int i = 0; i < 18; i++) begin
        m = (i < 16) ? (16'h0001 << i) : ((i == 16) ? 16'h0000 : 16'hffff);
        r1b = m[7:0] | m[15:8];
        r4a = m[7:0];
        r4b = m[15:8];
        wr(DEV, pgt_pkg::PGT_OFS_PG1_MASK_B, {r1b, r4a, r4b}, 1'b1);
        check_regs();
        apply(17'h1ffff, 8'h00);
        for (int k = 0; k < 17; k++) begin
          apply(~(17'h00001 << k), m[7:0]);
        end
        repeat (6) begin
          r = rnd();
          apply(r[16:0], r[31:24]);
        end
      end
      // Other device address and unmapped offsets must leave the bank alone
      r = rnd();
      wr(DEV ^ 7'h01, pgt_pkg::PGT_OFS_PG4_MASK_A, r[23:0], 1'b0);
      wr(DEV, 8'ha8, r[31:8], 1'b1);
      check_regs();
    end
    give_verdict();
  end
endmodule
